// ### hw/dcmc_pkg.sv
// constants, field layout and carrier types of the debug comparator match control
package dcmc_pkg;

    // -------------------------------------------------------------------
    // sizes
    // -------------------------------------------------------------------
    localparam int NUM_CMP = 3;
    localparam int APB_AW  = 8;
    localparam int ST_W    = 4;

    // -------------------------------------------------------------------
    // register indices; byte address is four times the index
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_CTL   = 8'h28;
    localparam logic [7:0] IDX_AH    = 8'h29;
    localparam logic [7:0] IDX_AM    = 8'h2A;
    localparam logic [7:0] IDX_AL    = 8'h2B;
    localparam logic [7:0] IDX_DH    = 8'h2C;
    localparam logic [7:0] IDX_DL    = 8'h2D;
    localparam logic [7:0] IDX_MH    = 8'h2E;
    localparam logic [7:0] IDX_ML    = 8'h2F;
    localparam logic [7:0] IDX_DCTL  = 8'h20;
    localparam logic [7:0] IDX_STAT  = 8'h30;
    localparam logic [7:0] IDX_IEN   = 8'h31;
    localparam logic [7:0] IDX_ICLR  = 8'h32;

    // -------------------------------------------------------------------
    // control register bit positions
    // -------------------------------------------------------------------
    localparam int BIT_SZE = 7;
    localparam int BIT_SZ  = 6;
    localparam int BIT_TAG = 5;
    localparam int BIT_BRK = 4;
    localparam int BIT_RW  = 3;
    localparam int BIT_RWE = 2;
    localparam int BIT_NDB = 1;
    localparam int BIT_EN  = 0;

    // implemented control bits per comparator
    localparam logic [7:0] CTL_MASK_A = 8'hFF;
    localparam logic [7:0] CTL_MASK_B = 8'hFD;
    localparam logic [7:0] CTL_MASK_C = 8'h3D;

    // debug control register layout
    localparam int DC_WIN  = 0;
    localparam int DC_MBE  = 4;
    localparam int DC_ARM  = 7;

    // status bits: one per channel match, then session end
    localparam int ST_END  = 3;

    // window select codes
    localparam logic [1:0] WIN_A    = 2'h0;
    localparam logic [1:0] WIN_B    = 2'h1;
    localparam logic [1:0] WIN_C    = 2'h2;
    localparam logic [1:0] WIN_NONE = 2'h3;

    // values after reset
    localparam logic [7:0]      RST_BYTE = 8'h00;
    localparam logic [1:0]      RST_AH   = 2'h0;
    localparam logic [ST_W-1:0] RST_ST   = 4'h0;

    // -------------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [17:0] addr;
        logic [15:0] data;
        logic        rd;
        logic        byte_acc;
        logic        valid;
    } dcmc_bus_obs_type;

endpackage : dcmc_pkg

// ### hw/dcmc_top.sv
// debug comparator match control: window registers, qualifiers, tagging, break
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module dcmc_top (
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [dcmc_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // observed processor bus and instruction queue
    input  wire dcmc_pkg::dcmc_bus_obs_type bus_obs,
    input  wire logic [2:0]                exec_tag,
    input  wire logic                      tag_flush,
    // state sequencer
    input  wire logic [2:0]                final_hint,
    input  wire logic                      seq_end,
    // match results
    output logic      [2:0]                match_out,
    output logic                           winner_valid,
    output logic      [1:0]                winner_chan,
    output logic                           session_end,
    output logic                           breakpoint_req,
    output logic                           armed,
    output logic                           irq
);

    // -------------------------------------------------------------------
    // byte addresses
    // -------------------------------------------------------------------
    localparam logic [7:0] ADR_CTL  = {dcmc_pkg::IDX_CTL[5:0], 2'h0};
    localparam logic [7:0] ADR_AH   = {dcmc_pkg::IDX_AH[5:0], 2'h0};
    localparam logic [7:0] ADR_AM   = {dcmc_pkg::IDX_AM[5:0], 2'h0};
    localparam logic [7:0] ADR_AL   = {dcmc_pkg::IDX_AL[5:0], 2'h0};
    localparam logic [7:0] ADR_DH   = {dcmc_pkg::IDX_DH[5:0], 2'h0};
    localparam logic [7:0] ADR_DL   = {dcmc_pkg::IDX_DL[5:0], 2'h0};
    localparam logic [7:0] ADR_MH   = {dcmc_pkg::IDX_MH[5:0], 2'h0};
    localparam logic [7:0] ADR_ML   = {dcmc_pkg::IDX_ML[5:0], 2'h0};
    localparam logic [7:0] ADR_DCTL = {dcmc_pkg::IDX_DCTL[5:0], 2'h0};
    localparam logic [7:0] ADR_STAT = {dcmc_pkg::IDX_STAT[5:0], 2'h0};
    localparam logic [7:0] ADR_IEN  = {dcmc_pkg::IDX_IEN[5:0], 2'h0};
    localparam logic [7:0] ADR_ICLR = {dcmc_pkg::IDX_ICLR[5:0], 2'h0};

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic [7:0]  ctl_reg   [dcmc_pkg::NUM_CMP];
    logic [7:0]  ctl_next  [dcmc_pkg::NUM_CMP];
    logic [1:0]  ah_reg    [dcmc_pkg::NUM_CMP];
    logic [1:0]  ah_next   [dcmc_pkg::NUM_CMP];
    logic [7:0]  am_reg    [dcmc_pkg::NUM_CMP];
    logic [7:0]  am_next   [dcmc_pkg::NUM_CMP];
    logic [7:0]  al_reg    [dcmc_pkg::NUM_CMP];
    logic [7:0]  al_next   [dcmc_pkg::NUM_CMP];
    logic [15:0] dcmp_reg;
    logic [15:0] dcmp_next;
    logic [15:0] dmask_reg;
    logic [15:0] dmask_next;
    logic [1:0]  win_reg;
    logic [1:0]  win_next;
    logic        mbe_reg;
    logic        mbe_next;
    logic        armed_reg;
    logic        armed_next;
    logic [2:0]  tag_pend_reg;
    logic [2:0]  tag_pend_next;
    logic [2:0]  match_reg;
    logic [2:0]  match_next;
    logic        wvalid_reg;
    logic        wvalid_next;
    logic [1:0]  wchan_reg;
    logic [1:0]  wchan_next;
    logic        end_reg;
    logic        end_next;
    logic        bkpt_reg;
    logic        bkpt_next;
    logic [dcmc_pkg::ST_W-1:0] st_reg;
    logic [dcmc_pkg::ST_W-1:0] st_next;
    logic [dcmc_pkg::ST_W-1:0] ien_reg;
    logic [dcmc_pkg::ST_W-1:0] ien_next;
    logic        irq_reg;
    logic        irq_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    logic        wr_take;
    logic        win_wr;
    logic [2:0]  fire;
    logic        end_now;
    logic [7:0]  rd_byte;
    logic        rd_hit;

    // a write lands only at the completing access edge
    assign wr_take = psel & penable & pready_reg & pwrite;
    assign win_wr  = wr_take & ~armed_reg;

    // implemented control bits per comparator
    function automatic logic [7:0] ctl_mask(input int n);
        logic [7:0] m;
        m = dcmc_pkg::CTL_MASK_C;
        if (n == 0) begin
            m = dcmc_pkg::CTL_MASK_A;
        end else if (n == 1) begin
            m = dcmc_pkg::CTL_MASK_B;
        end
        return m;
    endfunction : ctl_mask

    // -------------------------------------------------------------------
    // register readback
    // -------------------------------------------------------------------
    // window contents follow the select field; select 11 exposes nothing
    always_comb begin
        int sel;
        sel     = 0;
        rd_byte = dcmc_pkg::RST_BYTE;
        rd_hit  = 1'b1;
        if (win_reg != dcmc_pkg::WIN_NONE) begin
            sel = int'(win_reg);
        end
        case (paddr)
            ADR_CTL: begin
                if (win_reg != dcmc_pkg::WIN_NONE) begin
                    rd_byte = ctl_reg[sel];
                end
            end
            ADR_AH: begin
                if (win_reg != dcmc_pkg::WIN_NONE) begin
                    rd_byte = {6'h00, ah_reg[sel]};
                end
            end
            ADR_AM: begin
                if (win_reg != dcmc_pkg::WIN_NONE) begin
                    rd_byte = am_reg[sel];
                end
            end
            ADR_AL: begin
                if (win_reg != dcmc_pkg::WIN_NONE) begin
                    rd_byte = al_reg[sel];
                end
            end
            // data registers exist for comparator a only
            ADR_DH: begin
                if (win_reg == dcmc_pkg::WIN_A) begin
                    rd_byte = dcmp_reg[15:8];
                end
            end
            ADR_DL: begin
                if (win_reg == dcmc_pkg::WIN_A) begin
                    rd_byte = dcmp_reg[7:0];
                end
            end
            ADR_MH: begin
                if (win_reg == dcmc_pkg::WIN_A) begin
                    rd_byte = dmask_reg[15:8];
                end
            end
            ADR_ML: begin
                if (win_reg == dcmc_pkg::WIN_A) begin
                    rd_byte = dmask_reg[7:0];
                end
            end
            ADR_DCTL: begin
                rd_byte = {armed_reg, 2'h0, mbe_reg, 2'h0, win_reg};
            end
            ADR_STAT: begin
                rd_byte = {4'h0, st_reg};
            end
            ADR_IEN: begin
                rd_byte = {4'h0, ien_reg};
            end
            ADR_ICLR: begin
                rd_byte = dcmc_pkg::RST_BYTE;                    // write-only
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // -------------------------------------------------------------------
    // apb handshake
    // -------------------------------------------------------------------
    // no wait state; read data is registered in the setup cycle and leaves straight from a flop
    always_comb begin
        prdata_next  = prdata_reg;
        pready_next  = 1'b0;
        pslverr_next = 1'b0;
        if (psel && !penable) begin
            prdata_next  = {24'h000000, rd_byte};
            pready_next  = 1'b1;
            pslverr_next = ~rd_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h00000000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // -------------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------------
    // the window registers freeze while armed so a session sees a stable setup
    always_comb begin
        for (int n = 0; n < dcmc_pkg::NUM_CMP; n++) begin
            ctl_next[n] = ctl_reg[n];
            ah_next[n]  = ah_reg[n];
            am_next[n]  = am_reg[n];
            al_next[n]  = al_reg[n];
            if (win_wr && win_reg == 2'(n)) begin
                if (paddr == ADR_CTL) begin
                    ctl_next[n] = pwdata[7:0] & ctl_mask(n);
                end
                if (paddr == ADR_AH) begin
                    ah_next[n] = pwdata[1:0];
                end
                if (paddr == ADR_AM) begin
                    am_next[n] = pwdata[7:0];
                end
                if (paddr == ADR_AL) begin
                    al_next[n] = pwdata[7:0];
                end
            end
        end
        dcmp_next  = dcmp_reg;
        dmask_next = dmask_reg;
        if (win_wr && win_reg == dcmc_pkg::WIN_A) begin
            if (paddr == ADR_DH) dcmp_next[15:8] = pwdata[7:0];
            if (paddr == ADR_DL) dcmp_next[7:0] = pwdata[7:0];
            if (paddr == ADR_MH) dmask_next[15:8] = pwdata[7:0];
            if (paddr == ADR_ML) dmask_next[7:0] = pwdata[7:0];
        end
        win_next = win_reg;
        mbe_next = mbe_reg;
        if (wr_take && paddr == ADR_DCTL) begin
            win_next = pwdata[dcmc_pkg::DC_WIN +: 2];
            mbe_next = pwdata[dcmc_pkg::DC_MBE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int n = 0; n < dcmc_pkg::NUM_CMP; n++) begin
                ctl_reg[n] <= dcmc_pkg::RST_BYTE;
                ah_reg[n]  <= dcmc_pkg::RST_AH;
                am_reg[n]  <= dcmc_pkg::RST_BYTE;
                al_reg[n]  <= dcmc_pkg::RST_BYTE;
            end
            dcmp_reg  <= 16'h0000;
            dmask_reg <= 16'h0000;
            win_reg   <= dcmc_pkg::WIN_A;
            mbe_reg   <= 1'b0;
        end else begin
            for (int n = 0; n < dcmc_pkg::NUM_CMP; n++) begin
                ctl_reg[n] <= ctl_next[n];
                ah_reg[n]  <= ah_next[n];
                am_reg[n]  <= am_next[n];
                al_reg[n]  <= al_next[n];
            end
            dcmp_reg  <= dcmp_next;
            dmask_reg <= dmask_next;
            win_reg   <= win_next;
            mbe_reg   <= mbe_next;
        end
    end

    // -------------------------------------------------------------------
    // comparators and session control
    // -------------------------------------------------------------------
    // matches are only produced while armed; a break match disarms at once
    always_comb begin
        logic [2:0] hit;
        logic [2:0] fin;
        logic [2:0] pick;
        logic       addr_ok;
        logic       size_ok;
        logic       dir_ok;
        logic       data_ok;
        logic       tag;
        hit     = 3'h0;
        fin     = 3'h0;
        pick    = 3'h0;
        addr_ok = 1'b0;
        size_ok = 1'b0;
        dir_ok  = 1'b0;
        data_ok = 1'b0;
        tag     = 1'b0;
        for (int n = 0; n < dcmc_pkg::NUM_CMP; n++) begin
            tag     = ctl_reg[n][dcmc_pkg::BIT_TAG];
            addr_ok = bus_obs.addr == {ah_reg[n], am_reg[n], al_reg[n]};
            size_ok = ~ctl_reg[n][dcmc_pkg::BIT_SZE] | tag |
                      (bus_obs.byte_acc == ctl_reg[n][dcmc_pkg::BIT_SZ]);
            dir_ok  = ~ctl_reg[n][dcmc_pkg::BIT_RWE] | tag |
                      (bus_obs.rd == ctl_reg[n][dcmc_pkg::BIT_RW]);
            data_ok = 1'b1;
            if (n == 0) begin
                // masked-off bits match anything; polarity flips the outcome
                data_ok = tag | (((|((bus_obs.data ^ dcmp_reg) & dmask_reg))) ==
                          ctl_reg[0][dcmc_pkg::BIT_NDB]);
            end
            hit[n] = armed_reg & bus_obs.valid & ctl_reg[n][dcmc_pkg::BIT_EN] &
                     addr_ok & size_ok & dir_ok & data_ok;
            // tagged hits wait for execution; set beats an exec or flush clear, but a session end clears all
            tag_pend_next[n] = (hit[n] & tag) |
                               (tag_pend_reg[n] & ~exec_tag[n] & ~tag_flush & armed_reg);
            fire[n] = (hit[n] & ~tag) | (tag_pend_reg[n] & exec_tag[n] & armed_reg);
        end
        end_now = (|(fire & {ctl_reg[2][dcmc_pkg::BIT_BRK], ctl_reg[1][dcmc_pkg::BIT_BRK],
                             ctl_reg[0][dcmc_pkg::BIT_BRK]})) | (seq_end & armed_reg);
        if (end_now) begin
            tag_pend_next = 3'h0;
        end
        match_next = fire;
        // final-state matches first, then the lowest channel
        fin  = fire & final_hint;
        pick = (fin != 3'h0) ? fin : fire;
        wvalid_next = pick != 3'h0;
        wchan_next  = 2'h0;
        for (int n = dcmc_pkg::NUM_CMP - 1; n >= 0; n--) begin
            if (pick[n]) begin
                wchan_next = 2'(n);
            end
        end
        end_next  = end_now;
        bkpt_next = end_now & mbe_reg & ~seq_end;
        bkpt_next = bkpt_next | ((|(fire & {ctl_reg[2][dcmc_pkg::BIT_BRK],
                    ctl_reg[1][dcmc_pkg::BIT_BRK], ctl_reg[0][dcmc_pkg::BIT_BRK]})) & mbe_reg);
        armed_next = armed_reg;
        if (wr_take && paddr == ADR_DCTL) begin
            armed_next = pwdata[dcmc_pkg::DC_ARM];
        end
        if (end_now) begin
            armed_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tag_pend_reg <= 3'h0;
            match_reg    <= 3'h0;
            wvalid_reg   <= 1'b0;
            wchan_reg    <= 2'h0;
            end_reg      <= 1'b0;
            bkpt_reg     <= 1'b0;
            armed_reg    <= 1'b0;
        end else begin
            tag_pend_reg <= tag_pend_next;
            match_reg    <= match_next;
            wvalid_reg   <= wvalid_next;
            wchan_reg    <= wchan_next;
            end_reg      <= end_next;
            bkpt_reg     <= bkpt_next;
            armed_reg    <= armed_next;
        end
    end

    // -------------------------------------------------------------------
    // interrupt status
    // -------------------------------------------------------------------
    // a new event in the clearing cycle survives the clear
    always_comb begin
        logic [dcmc_pkg::ST_W-1:0] clr;
        clr = '0;
        if (wr_take && paddr == ADR_ICLR) begin
            clr = pwdata[dcmc_pkg::ST_W-1:0];
        end
        st_next  = (st_reg & ~clr) | {end_now, fire};
        ien_next = ien_reg;
        if (wr_take && paddr == ADR_IEN) begin
            ien_next = pwdata[dcmc_pkg::ST_W-1:0];
        end
        irq_next = |(st_next & ien_next);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg  <= dcmc_pkg::RST_ST;
            ien_reg <= dcmc_pkg::RST_ST;
            irq_reg <= 1'b0;
        end else begin
            st_reg  <= st_next;
            ien_reg <= ien_next;
            irq_reg <= irq_next;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign match_out      = match_reg;
    assign winner_valid   = wvalid_reg;
    assign winner_chan    = wchan_reg;
    assign session_end    = end_reg;
    assign breakpoint_req = bkpt_reg;
    assign armed          = armed_reg;
    assign irq            = irq_reg;

endmodule : dcmc_top

// ### bench/dcmc_checker.sv
// port assertions of the debug comparator match control
`timescale 1ns/1ns
module dcmc_checker (
    // clock, reset and apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // match results
    input wire logic [2:0]  match_out,
    input wire logic        winner_valid,
    input wire logic [1:0]  winner_chan,
    input wire logic        session_end,
    input wire logic        breakpoint_req,
    input wire logic        armed
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a setup cycle gets exactly one access cycle
    property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("apb answer timing wrong");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error reply carries data");
    property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    // nothing is compared while disarmed
    property p_off; !armed |=> match_out == 3'h0; endproperty
    a_off: assert property (p_off) else $error("match while disarmed");
    property p_brk; breakpoint_req |-> session_end; endproperty
    a_brk: assert property (p_brk) else $error("breakpoint without end");
    property p_end; session_end |-> !armed && $past(armed); endproperty
    a_end: assert property (p_end) else $error("session end without disarm");
    property p_win; winner_valid |-> match_out[winner_chan]; endproperty
    a_win: assert property (p_win) else $error("winner did not match");
    property p_wv; winner_valid == (match_out != 3'h0); endproperty
    a_wv: assert property (p_wv) else $error("winner flag wrong");
endmodule : dcmc_checker

// ### bench/dcmc_bus_model.sv
// behavioural model of the watched processor bus
`timescale 1ns/1ns
module dcmc_bus_model (
    // clock and cycle request
    input  wire logic                       pclk,
    input  wire dcmc_pkg::dcmc_bus_obs_type req,
    // bus seen by the comparators
    output dcmc_pkg::dcmc_bus_obs_type      obs
);
    dcmc_pkg::dcmc_bus_obs_type last = '0;
    // idle cycles show the inverse of the last cycle so stale data never matches by luck
    always_comb begin
        obs = req.valid ? req : ~last;
        obs.valid = req.valid;
    end
    always @(posedge pclk) if (req.valid) last <= req;
endmodule : dcmc_bus_model

// ### bench/testbench.sv
// self-checking bench of the debug comparator match control
`timescale 1ns/1ns
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, winner_valid, session_end, breakpoint_req, armed, irq, ev;
    logic [7:0]  paddr = 8'h00, rv;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [2:0]  match_out, exec_tag = 3'h0, fh = 3'h0;
    logic [1:0]  winner_chan;
    logic [17:0] ad;
    logic [15:0] dt;
    dcmc_pkg::dcmc_bus_obs_type req = '0, obs;
    int fails = 0, cmp_count = 0, cyc = 0;
    // {addr miss, expect, data flip, byte, read, control}
    logic [15:0] tc [10] = '{16'h0801, 16'h0000, 16'h000D, 16'h090D, 16'h00C1,
                             16'h0AC1, 16'h0003, 16'h0C03, 16'h1001, 16'h082F};
    dcmc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_obs(obs), .exec_tag(exec_tag), .tag_flush(1'b0),
        .final_hint(fh), .seq_end(1'b0), .match_out(match_out),
        .winner_valid(winner_valid), .winner_chan(winner_chan), .session_end(session_end),
        .breakpoint_req(breakpoint_req), .armed(armed), .irq(irq));
    dcmc_bus_model i_bus (.pclk(pclk), .req(req), .obs(obs));
    always #2 pclk = ~pclk;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; the slave decides when it answers
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i[5:0], 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata[7:0];
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk(rv, e);
    endtask : rd
    task automatic bus(input logic r, input logic b);
        @(posedge pclk);
        req <= '{addr: ad, data: dt, rd: r, byte_acc: b, valid: 1'b1};
        @(posedge pclk);
        req.valid <= 1'b0;
        #1;
    endtask : bus
    // disarm, load comparator a with ad and dt under a full mask, then set control
    task automatic cfg(input logic [7:0] c, input logic [7:0] dc);
        apb(1'b1, dcmc_pkg::IDX_DCTL, 8'h00);
        apb(1'b1, dcmc_pkg::IDX_AH, {6'h0, ad[17:16]});
        apb(1'b1, dcmc_pkg::IDX_AM, ad[15:8]);
        apb(1'b1, dcmc_pkg::IDX_AL, ad[7:0]);
        apb(1'b1, dcmc_pkg::IDX_DH, dt[15:8]);
        apb(1'b1, dcmc_pkg::IDX_DL, dt[7:0]);
        apb(1'b1, dcmc_pkg::IDX_MH, 8'hFF);
        apb(1'b1, dcmc_pkg::IDX_ML, 8'hFF);
        apb(1'b1, dcmc_pkg::IDX_CTL, c);
        apb(1'b1, dcmc_pkg::IDX_DCTL, dc);
    endtask : cfg
    initial begin
        void'($urandom(71749));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(dcmc_pkg::IDX_CTL, 8'h00);
        apb(1'b1, dcmc_pkg::IDX_IEN, 8'h0F);
        for (int w = 0; w < 3; w++) begin
            apb(1'b1, dcmc_pkg::IDX_DCTL, w[7:0]);
            apb(1'b1, dcmc_pkg::IDX_CTL, 8'hFF);
            apb(1'b1, dcmc_pkg::IDX_DH, 8'h5A);
            rd(dcmc_pkg::IDX_CTL, w == 0 ? 8'hFF : w == 1 ? 8'hFD : 8'h3D);
            rd(dcmc_pkg::IDX_DH, w == 0 ? 8'h5A : 8'h00);
            apb(1'b1, dcmc_pkg::IDX_AH, 8'hFF);
            rd(dcmc_pkg::IDX_AH, 8'h03);
        end
        apb(1'b1, dcmc_pkg::IDX_DCTL, 8'h03);
        rd(dcmc_pkg::IDX_AH, 8'h00);
        apb(1'b1, dcmc_pkg::IDX_DCTL, 8'h00);
        rd(dcmc_pkg::IDX_CTL, 8'hFF);
        apb(1'b0, 8'h01, 8'h00);
        chk({7'h0, ev}, 8'h01);
        // qualifier table: size, direction, polarity, enable, address and tag
        foreach (tc[k]) begin
            ad = 18'($urandom);
            dt = 16'($urandom);
            cfg(tc[k][7:0], 8'h80);
            if (tc[k][12]) ad = ad ^ 18'h1;
            if (tc[k][10]) dt = ~dt;
            bus(tc[k][8], tc[k][9]);
            chk({5'h0, match_out}, {7'h0, tc[k][11] & ~tc[k][5]});
            if (tc[k][5]) begin
                @(posedge pclk);
                exec_tag <= 3'h1;
                @(posedge pclk);
                exec_tag <= 3'h0;
                #1;
                chk({5'h0, match_out}, 8'h01);
            end
        end
        apb(1'b1, dcmc_pkg::IDX_CTL, 8'h00);
        rd(dcmc_pkg::IDX_CTL, 8'h2F);
        apb(1'b1, dcmc_pkg::IDX_AH, 8'h00);
        rd(dcmc_pkg::IDX_AH, {6'h0, ad[17:16]});
        apb(1'b1, dcmc_pkg::IDX_ICLR, 8'h0F);
        cfg(8'h11, 8'h90);
        bus(1'b0, 1'b0);
        chk({5'h0, session_end, breakpoint_req, armed}, 8'h06);
        chk({7'h0, irq}, 8'h01);
        rd(dcmc_pkg::IDX_STAT, 8'h09);
        apb(1'b1, dcmc_pkg::IDX_IEN, 8'h00);
        #1;
        chk({7'h0, irq}, 8'h00);
        apb(1'b1, dcmc_pkg::IDX_ICLR, 8'h0F);
        rd(dcmc_pkg::IDX_STAT, 8'h00);
        cfg(8'h11, 8'h80);
        bus(1'b0, 1'b0);
        chk({5'h0, session_end, breakpoint_req, armed}, 8'h04);
        // a and b hit together; the final-state hint lets b win over the lower channel
        cfg(8'h01, 8'h01);
        apb(1'b1, dcmc_pkg::IDX_AH, {6'h0, ad[17:16]});
        apb(1'b1, dcmc_pkg::IDX_AM, ad[15:8]);
        apb(1'b1, dcmc_pkg::IDX_AL, ad[7:0]);
        apb(1'b1, dcmc_pkg::IDX_CTL, 8'h01);
        apb(1'b1, dcmc_pkg::IDX_DCTL, 8'h81);
        fh <= 3'h2;
        bus(1'b0, 1'b0);
        chk({3'h0, winner_valid, winner_chan, match_out[1:0]}, 8'h17);
        close_out();
    end
endmodule : testbench
bind dcmc_top dcmc_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .match_out(match_out), .winner_valid(winner_valid), .winner_chan(winner_chan),
    .session_end(session_end), .breakpoint_req(breakpoint_req), .armed(armed));
